// >>> src/tsl_status_ctrl.sv
// top of the tracker status led and emergency controller with its wishbone slave
// assumes status inputs come from logic on clk_i; buttons and external power are pins
module tsl_status_ctrl
   import tsl_pkg::*;
#(
   parameter int unsigned TICK_CYCLES     = TICK_CYCLES_DEF,
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_DEF
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        pwr_btn_i,
   input  wire logic        bt_btn_i,
   input  wire logic        ext_power_i,
   input  wire logic [1:0]  battery_level_led_level_i,
   input  wire logic        charging_i,
   input  wire logic        charge_done_i,
   input  wire logic [1:0]  fix_i,
   input  wire logic        link_connected_i,
   input  wire logic [1:0]  report_state_i,
   input  wire logic [2:0]  sat_bars_i,
   input  wire logic        sleep_req_i,
   input  wire logic        radio_data_i,
   input  wire logic        at_cmd_i,
   output logic      [5:0]  led_o,
   output logic             power_on_o,
   output logic             awake_o,
   output logic             radio_on_o,
   output logic             report_req_o,
   output logic             report_emergency_o,
   output logic             msg_emergency_o,
   output logic             at_ok_o
);
   tsl_btn_if btn ();

   logic [31:0]  tick_cnt;
   logic         tick;
   logic [8:0]   phase;
   logic [5:0]   led_en;
   logic [15:0]  emg_interval;
   logic [15:0]  idle_limit;
   logic         power_on;
   logic         emergency;
   logic         awake;
   logic [9:0]   wake_cnt;
   logic         radio_on;
   logic [15:0]  idle_cnt;
   logic [15:0]  rep_cnt;
   logic         ext_meta;
   logic         ext_sync;
   logic         ext_prev;
   logic [4:0]   chg_cnt;
   logic         chg_active;
   logic [1:0]   chg_idx;
   tsl_seq_type  seq_st;
   logic         seq_hit;
   logic         emg_start;
   logic         pwr_toggle;
   logic         power_off;
   logic         ext_rise;
   logic         wb_req;
   logic [5:0]   next_led;

   tsl_buttons #(
      .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES)
   ) u_buttons (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .pwr_btn_i (pwr_btn_i),
      .bt_btn_i  (bt_btn_i),
      .btn       (btn)
   );

   function automatic logic win(input logic [8:0] ph, input logic [8:0] per, input logic [8:0] on);
      return (ph % per) < on;
   endfunction : win

   // one tick feeds every blink, timeout and hold count
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt <= 32'h0;
         tick     <= 1'b0;
      end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= 32'h0;
         tick     <= 1'b1; // [RULE23]
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick     <= 1'b0;
      end
   end
   assign btn.tick = tick;

   // phase spans the common multiple of all blink periods, so patterns never jump
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase <= 9'h0;
      end else if (tick) begin
         phase <= (phase == PHASE_LEN - 9'h1) ? 9'h0 : phase + 9'h1;
      end
   end

   // emergency press sequence, watched whether powered or not
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seq_st <= SEQ_IDLE;
      end else if (btn.down[BTN_PWR]) begin
         seq_st <= (seq_st == SEQ_PB) ? SEQ_PBP : SEQ_P; // [RULE1] [RULE4]
      end else if (btn.down[BTN_BT]) begin
         seq_st <= (seq_st == SEQ_P) ? SEQ_PB : SEQ_IDLE; // [RULE1]
      end
   end
   assign seq_hit    = btn.down[BTN_BT] && seq_st == SEQ_PBP;
   assign emg_start  = seq_hit && !emergency;
   assign pwr_toggle = btn.long_rel[BTN_PWR];
   assign power_off  = pwr_toggle && power_on && !seq_hit;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_on <= 1'b0;
      end else if (seq_hit) begin
         power_on <= 1'b1; // [RULE4]
      end else if (pwr_toggle) begin
         power_on <= !power_on; // [RULE21]
      end
   end

   // the sequence wins over a power-off landing in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         emergency <= 1'b0;
      end else if (seq_hit) begin
         emergency <= 1'b1; // [RULE1]
      end else if (power_off) begin
         emergency <= 1'b0; // [RULE5]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_cnt <= 10'h0;
      end else if (!power_on) begin
         wake_cnt <= 10'h0;
      end else if (btn.down[BTN_BT] && !awake) begin
         wake_cnt <= WAKE_BT_TICKS; // [RULE22]
      end else if (btn.short_rel[BTN_PWR] && !awake) begin
         wake_cnt <= WAKE_PWR_TICKS; // [RULE21]
      end else if (tick && wake_cnt != 10'h0) begin
         wake_cnt <= wake_cnt - 10'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         awake <= 1'b0;
      end else begin
         awake <= power_on && (!sleep_req_i || wake_cnt != 10'h0);
      end
   end

   // wireless link on/off and its idle timer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         radio_on <= 1'b0;
      end else if (!power_on) begin
         radio_on <= 1'b0;
      end else if (btn.long_rel[BTN_BT]) begin
         radio_on <= !radio_on; // [RULE22]
      end else if (radio_on && idle_cnt >= idle_limit) begin
         radio_on <= 1'b0; // [RULE19]
      end
   end

   // being connected does not hold the timer off; only traffic restarts it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idle_cnt <= 16'h0;
      end else if (!radio_on || radio_data_i || at_cmd_i) begin
         idle_cnt <= 16'h0; // [RULE20]
      end else if (tick && idle_cnt != 16'hffff) begin
         idle_cnt <= idle_cnt + 16'h1; // [RULE19]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         at_ok_o <= 1'b0;
      end else begin
         at_ok_o <= at_cmd_i; // [RULE20]
      end
   end

   // emergency reporting: one report at entry, then one per interval
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rep_cnt      <= 16'h0;
         report_req_o <= 1'b0;
      end else if (emg_start) begin
         rep_cnt      <= 16'h0;
         report_req_o <= 1'b1; // [RULE2]
      end else if (emergency && power_on && tick) begin
         if (rep_cnt + 16'h1 >= emg_interval) begin
            rep_cnt      <= 16'h0;
            report_req_o <= 1'b1; // [RULE2]
         end else begin
            rep_cnt      <= rep_cnt + 16'h1;
            report_req_o <= 1'b0;
         end
      end else begin
         report_req_o <= 1'b0;
      end
   end
   assign report_emergency_o = emergency; // [RULE2]
   assign msg_emergency_o    = emergency; // [RULE3]
   assign power_on_o         = power_on;
   assign awake_o            = awake;
   assign radio_on_o         = radio_on;

   // charger pattern; the external power pin crosses in through two flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ext_meta <= 1'b0;
         ext_sync <= 1'b0;
         ext_prev <= 1'b0;
      end else begin
         ext_meta <= ext_power_i;
         ext_sync <= ext_meta;
         ext_prev <= ext_sync;
      end
   end
   assign ext_rise = ext_sync && !ext_prev;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chg_cnt <= 5'h0;
      end else if (!power_on) begin
         chg_cnt <= 5'h0;
      end else if (ext_rise) begin
         chg_cnt <= CHG_TICKS; // [RULE16]
      end else if (tick && chg_cnt != 5'h0) begin
         chg_cnt <= chg_cnt - 5'h1;
      end
   end
   assign chg_active = chg_cnt != 5'h0;
   assign chg_idx    = 2'(((CHG_TICKS - chg_cnt) / CHG_STEP_TICKS) % 5'h4);

   // led selection: off, then asleep, then emergency, then charger sweep, then normal states
   always_comb begin
      next_led = 6'h00;
      if (!power_on) begin
         next_led = 6'h00; // [RULE18]
      end else if (!awake) begin
         next_led[LED_PWR] = win(phase, emergency ? SLP_EMG_PER : SLP_NORM_PER, SLP_ON); // [RULE7]
      end else if (emergency) begin
         next_led = {6{win(phase, EMG_PER, EMG_ON)}}; // [RULE6]
      end else begin
         next_led[LED_PWR] = 1'b1; // [RULE8]
         if (chg_active) begin
            unique case (chg_idx)
               2'h0: next_led[LED_BATTERY_LEVEL_LED] = 1'b1; // [RULE16]
               2'h1: next_led[LED_POS]  = 1'b1;
               2'h2: next_led[LED_SAT]  = 1'b1;
               2'h3: next_led[LED_REP]  = 1'b1;
            endcase
         end else begin
            // normal patterns resume as soon as the sweep ends
            if (charging_i) begin
               next_led[LED_BATTERY_LEVEL_LED] = charge_done_i || win(phase, BMID_PER, BMID_ON); // [RULE11] [RULE17]
            end else begin
               unique case (battery_level_led_level_i)
                  BATTERY_LEVEL_LED_NEED: next_led[LED_BATTERY_LEVEL_LED] = 1'b0; // [RULE10]
                  BATTERY_LEVEL_LED_LOW:  next_led[LED_BATTERY_LEVEL_LED] = win(phase, BLOW_PER, BLOW_ON);
                  BATTERY_LEVEL_LED_MID:  next_led[LED_BATTERY_LEVEL_LED] = win(phase, BMID_PER, BMID_ON);
                  BATTERY_LEVEL_LED_FULL: next_led[LED_BATTERY_LEVEL_LED] = 1'b1;
               endcase
            end
            next_led[LED_POS]  = fix_i == FIX_3D || (fix_i == FIX_2D && win(phase, SEC_PER, SEC_ON)); // [RULE12]
            next_led[LED_LINK] = radio_on && (link_connected_i || win(phase, SEC_PER, SEC_ON)); // [RULE13]
            next_led[LED_REP]  = report_state_i == REP_OK ||
                                 (report_state_i == REP_FAIL && win(phase, SEC_PER, SEC_ON)); // [RULE14]
            next_led[LED_SAT]  = sat_bars_i >= 3'h3 ||
                                 (sat_bars_i != 3'h0 && win(phase, SEC_PER, SEC_ON)); // [RULE15]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_o <= 6'h00;
      end else begin
         led_o <= next_led & led_en; // [RULE9]
      end
   end

   // wishbone slave: ack one cycle after the request, writes land on the ack edge
   assign wb_req = wb_cyc_i && wb_stb_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         wb_ack_o <= wb_req && !wb_ack_o;
         if (wb_req && !wb_ack_o) begin
            unique case (wb_adr_i)
               ADR_LED_EN:  wb_dat_o <= {26'h0, led_en};
               ADR_STATUS:  wb_dat_o <= {26'h0, chg_active, radio_on, emergency, awake, power_on, report_req_o};
               ADR_EMG_INT: wb_dat_o <= {16'h0, emg_interval};
               ADR_IDLE:    wb_dat_o <= {16'h0, idle_limit};
               default:     wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_en       <= LED_EN_RST;
         emg_interval <= EMG_INT_RST;
         idle_limit   <= IDLE_RST;
      end else if (wb_req && wb_we_i && wb_ack_o) begin
         if (wb_adr_i == ADR_LED_EN && wb_sel_i[0]) begin
            led_en <= wb_dat_i[5:0]; // [RULE9]
         end
         if (wb_adr_i == ADR_EMG_INT) begin
            if (wb_sel_i[0]) emg_interval[7:0] <= wb_dat_i[7:0]; // [RULE2]
            if (wb_sel_i[1]) emg_interval[15:8] <= wb_dat_i[15:8];
         end
         if (wb_adr_i == ADR_IDLE) begin
            if (wb_sel_i[0]) idle_limit[7:0] <= wb_dat_i[7:0]; // [RULE19]
            if (wb_sel_i[1]) idle_limit[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_off_dark: assert property (!power_on |=> led_o == 6'h00) // [RULE18]
      else $error("led_enable_setting lit while powered off");
   chk_enable_mask: assert property (##1 (led_o & ~$past(led_en)) == 6'h00) // [RULE9]
      else $error("disabled led is lit");
   chk_emg_report: assert property (emg_start |=> report_req_o && report_emergency_o) // [RULE2]
      else $error("no flagged report on emergency entry");
   chk_seq_enter: assert property (seq_hit |=> msg_emergency_o && power_on) // [RULE1]
      else $error("sequence did not enter emergency");
   chk_seq_off: assert property (!power_on && seq_hit |=> emergency ##1 emergency || !power_on) // [RULE4]
      else $error("sequence ignored while off");
   chk_off_clears: assert property (power_off |=> !emergency && !power_on && !msg_emergency_o) // [RULE5]
      else $error("power-off kept emergency");
   chk_awake_led: assert property (power_on && awake && !emergency && led_en[LED_PWR] |=> led_o[LED_PWR]) // [RULE8]
      else $error("power led dark while awake");
   chk_emg_blink: assert property (power_on && awake && emergency |=> led_o == 6'h00 || led_o == $past(led_en)) // [RULE6]
      else $error("emergency led_enable_setting not in step");
   chk_at_answer: assert property (at_cmd_i |=> at_ok_o && idle_cnt == 16'h0) // [RULE20]
      else $error("attention not answered");
   chk_idle_off: assert property (radio_on && power_on && !btn.long_rel[BTN_BT] && idle_cnt >= idle_limit
                                  |=> !radio_on) // [RULE19]
      else $error("idle timeout missed");
   chk_charger_len: assert property (power_on && ext_rise |=> chg_cnt == CHG_TICKS || !power_on) // [RULE16]
      else $error("charger sweep not started");

   cov_emergency: cover property (emg_start ##1 report_req_o);
   cov_charger:   cover property (chg_active && tick);
   cov_idle_off:  cover property (radio_on ##1 !radio_on);
   cov_sleep_emg: cover property (power_on && !awake && emergency && led_o[LED_PWR]);
endmodule : tsl_status_ctrl

// >>> src/tsl_pkg.sv
// constants, encodings and register map of the tracker status/emergency controller
// assumes one 200 MHz clock; all slow timing counts 125 ms ticks
// How it works
// RULE1: power, wireless, power, wireless presses enter emergency mode
// RULE2: emergency entry sends a flagged report at once, then at the set interval
// RULE3: outgoing messages carry the emergency flag while emergency is active
// RULE4: the press sequence is detected whether the unit is on or off
// RULE5: power-off clears emergency; only a new sequence brings it back
// RULE6: awake in emergency, all six led_enable_setting blink 0.5 s on, 0.5 s off
// RULE7: asleep, power led blinks every 2.5 s in emergency, else 5 s
// RULE8: power led dark when off, steady when on and awake
// RULE9: each led has its own enable bit; disabled led_enable_setting stay dark
// RULE10: battery led dark, slow blink, short blink or steady by charge level
// RULE11: charging shows 1.25/0.25 s blink, steady once charging completes
// RULE12: positioning led dark, blinking for 2-D or dead reckoning, steady for 3-D
// RULE13: wireless led dark when off, 1 s blink unconnected, steady connected
// RULE14: report led dark with no success, 1 s blink failed, steady succeeded
// RULE15: satellite led dark without signal, blink 1-2 bars, steady 3-5 bars
// RULE16: external power while on rotates four led_enable_setting clockwise for 3 s
// RULE17: after a special pattern every led returns to its normal pattern
// RULE18: all led_enable_setting dark while off, even when charging
// RULE19: wireless turns off after the idle time without data or connection; here a connection does not hold the timer off
// RULE20: bare attention command is answered ok and restarts the idle timer
// RULE21: 2 s power hold toggles power; short press while asleep wakes 10 s
// RULE22: 2 s wireless hold toggles link; wireless press while asleep wakes 2 min
// RULE23: all slow timing from one shared tick; buttons debounced first
package tsl_pkg;
   localparam int unsigned CLK_MHZ         = 200;
   localparam int unsigned TICK_MS         = 125;
   localparam int unsigned TICK_CYCLES_DEF = TICK_MS * 1000 * CLK_MHZ;
   localparam int unsigned DEBOUNCE_MS     = 10;
   localparam int unsigned DEBOUNCE_DEF    = DEBOUNCE_MS * 1000 * CLK_MHZ;
   localparam int unsigned HOLD_MS         = 2000;
   localparam int unsigned WAKE_PWR_MS     = 10000;
   localparam int unsigned WAKE_BT_MS      = 120000;
   localparam int unsigned IDLE_MS         = 600000;
   localparam int unsigned EMG_INT_MS      = 300000;
   localparam int unsigned CHG_MS          = 3000;
   localparam int unsigned CHG_STEP_MS     = 250;
   localparam logic [4:0]  HOLD_TICKS      = 5'(HOLD_MS / TICK_MS);
   localparam logic [9:0]  WAKE_PWR_TICKS  = 10'(WAKE_PWR_MS / TICK_MS);
   localparam logic [9:0]  WAKE_BT_TICKS   = 10'(WAKE_BT_MS / TICK_MS);
   localparam logic [15:0] IDLE_RST        = 16'(IDLE_MS / TICK_MS);
   localparam logic [15:0] EMG_INT_RST     = 16'(EMG_INT_MS / TICK_MS);
   localparam logic [4:0]  CHG_TICKS       = 5'(CHG_MS / TICK_MS);
   localparam logic [4:0]  CHG_STEP_TICKS  = 5'(CHG_STEP_MS / TICK_MS);
   // blink periods and on-times in ticks
   localparam logic [8:0]  PHASE_LEN       = 9'h168;
   localparam logic [8:0]  EMG_PER         = 9'(1000 / TICK_MS);
   localparam logic [8:0]  EMG_ON          = 9'(500 / TICK_MS);
   localparam logic [8:0]  SLP_NORM_PER    = 9'(5000 / TICK_MS);
   localparam logic [8:0]  SLP_EMG_PER     = 9'(2500 / TICK_MS);
   localparam logic [8:0]  SLP_ON          = 9'h001;
   localparam logic [8:0]  BMID_PER        = 9'((1250 + 250) / TICK_MS);
   localparam logic [8:0]  BMID_ON         = 9'(1250 / TICK_MS);
   localparam logic [8:0]  BLOW_PER        = 9'((125 + 1000) / TICK_MS);
   localparam logic [8:0]  BLOW_ON         = 9'(125 / TICK_MS);
   localparam logic [8:0]  SEC_PER         = 9'(1000 / TICK_MS);
   localparam logic [8:0]  SEC_ON          = 9'(500 / TICK_MS);
   // register byte offsets
   localparam logic [7:0]  ADR_LED_EN      = 8'h00;
   localparam logic [7:0]  ADR_STATUS      = 8'h04;
   localparam logic [7:0]  ADR_EMG_INT     = 8'h08;
   localparam logic [7:0]  ADR_IDLE        = 8'h0c;
   localparam logic [5:0]  LED_EN_RST      = 6'h3f;
   // led positions
   localparam int unsigned LED_PWR  = 0;
   localparam int unsigned LED_BATTERY_LEVEL_LED = 1;
   localparam int unsigned LED_POS  = 2;
   localparam int unsigned LED_LINK = 3;
   localparam int unsigned LED_REP  = 4;
   localparam int unsigned LED_SAT  = 5;
   // button positions and status input codes
   localparam int unsigned BTN_PWR = 0;
   localparam int unsigned BTN_BT  = 1;
   localparam logic [1:0]  BATTERY_LEVEL_LED_NEED = 2'h0, BATTERY_LEVEL_LED_LOW = 2'h1, BATTERY_LEVEL_LED_MID = 2'h2, BATTERY_LEVEL_LED_FULL = 2'h3;
   localparam logic [1:0]  FIX_OFF = 2'h0, FIX_TIME = 2'h1, FIX_2D = 2'h2, FIX_3D = 2'h3;
   localparam logic [1:0]  REP_NONE = 2'h0, REP_FAIL = 2'h1, REP_OK = 2'h2;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_P, SEQ_PB, SEQ_PBP} tsl_seq_type;
endpackage : tsl_pkg

// >>> src/tsl_btn_if.sv
// button events passed from the button front end to the controller
// assumes both ends run on the same clock
interface tsl_btn_if;
   logic       tick;
   logic [1:0] down;
   logic [1:0] short_rel;
   logic [1:0] long_rel;
   modport src  (input tick, output down, short_rel, long_rel);
   modport sink (output tick, input down, short_rel, long_rel);
endinterface : tsl_btn_if

// >>> src/tsl_buttons.sv
// synchroniser, debouncer and press classifier for the two buttons
// assumes raw active-high button pins and the shared tick from the controller
module tsl_buttons
   import tsl_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_DEF
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic pwr_btn_i,
   input  wire logic bt_btn_i,
   tsl_btn_if.src    btn
);
   logic [1:0]  meta;
   logic [1:0]  sync;
   logic [1:0]  stable;
   logic [1:0]  prev;
   logic [31:0] deb_cnt [2];
   logic [4:0]  hold [2];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= 2'h0;
         sync <= 2'h0;
      end else begin
         meta <= {bt_btn_i, pwr_btn_i};
         sync <= meta;
      end
   end

   // a level must persist a full debounce window before it is believed
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (rst_i) begin
            stable[i]  <= 1'b0;
            deb_cnt[i] <= 32'h0;
         end else if (sync[i] == stable[i]) begin
            deb_cnt[i] <= 32'h0;
         end else if (deb_cnt[i] >= 32'(DEBOUNCE_CYCLES - 1)) begin
            stable[i]  <= sync[i]; // [RULE23]
            deb_cnt[i] <= 32'h0;
         end else begin
            deb_cnt[i] <= deb_cnt[i] + 32'h1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (rst_i) begin
            hold[i] <= 5'h0;
         end else if (stable[i] && !prev[i]) begin
            hold[i] <= 5'h0;
         end else if (stable[i] && btn.tick && hold[i] < HOLD_TICKS) begin
            hold[i] <= hold[i] + 5'h1; // [RULE23]
         end
      end
   end

   // release after a full hold is a long press, anything shorter a short one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev          <= 2'h0;
         btn.down      <= 2'h0;
         btn.short_rel <= 2'h0;
         btn.long_rel  <= 2'h0;
      end else begin
         prev <= stable;
         btn.down <= stable & ~prev;
         for (int i = 0; i < 2; i++) begin
            btn.short_rel[i] <= !stable[i] && prev[i] && hold[i] < HOLD_TICKS;
            btn.long_rel[i]  <= !stable[i] && prev[i] && hold[i] >= HOLD_TICKS; // [RULE21] [RULE22]
         end
      end
   end
endmodule : tsl_buttons

// >>> bench/tsl_operator.sv
// behavioural operator pressing the two buttons of the tracker
// assumes released buttons read low through the pin pull-down
module tsl_operator (
   input  wire logic clk_i,
   output logic      pwr_btn_o,
   output logic      bt_btn_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pwr_btn_o = 1'b0;
      bt_btn_o  = 1'b0;
   end
   // a gap after each release lets the debouncer settle before the next press
   task automatic press(input int b, input int n);
      @(posedge clk_i);
      if (b == 0) pwr_btn_o <= 1'b1;
      else bt_btn_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      pwr_btn_o <= 1'b0;
      bt_btn_o  <= 1'b0;
      repeat (20) @(posedge clk_i);
   endtask : press
endmodule : tsl_operator

// >>> bench/tsl_status_ctrl_test.sv
// self-checking bench for the status led and emergency controller
// assumes a tick of 8 cycles and a debounce of 2 cycles
module tsl_status_ctrl_test;
   import tsl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, at_cmd = 0, slp = 0, pb, bb;
   logic [7:0] adr = 0;
   logic [31:0] dat = 0, q, dat_o;
   logic [5:0] led;
   logic ext = 0, chg = 0;
   logic [1:0] battery_level_led = BATTERY_LEVEL_LED_FULL, fix = FIX_3D;
   logic [2:0] sat = 3'h4;
   logic ack, pwr_on, awake, radio, rreq, remg, memg, at_ok;
   int fail_count = 0, samples_checked = 0, cycles = 0, reports = 0, oks = 0, lit;
   always #2.5 clk_i = ~clk_i;
   tsl_operator op (.clk_i(clk_i), .pwr_btn_o(pb), .bt_btn_o(bb));
   tsl_status_ctrl #(.TICK_CYCLES(8), .DEBOUNCE_CYCLES(2)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pwr_btn_i(pb), .bt_btn_i(bb),
      .ext_power_i(ext), .battery_level_led_level_i(battery_level_led), .charging_i(chg), .charge_done_i(1'b0),
      .fix_i(fix), .link_connected_i(1'b1), .report_state_i(REP_OK), .sat_bars_i(sat),
      .sleep_req_i(slp), .radio_data_i(1'b0), .at_cmd_i(at_cmd), .led_o(led), .power_on_o(pwr_on),
      .awake_o(awake), .radio_on_o(radio), .report_req_o(rreq), .report_emergency_o(remg),
      .msg_emergency_o(memg), .at_ok_o(at_ok));
   // the ceiling is over eight times the length of the full sequence
   always @(posedge clk_i) begin
      cycles++;
      if (rreq === 1'b1) reports++;
      if (at_ok === 1'b1) oks++;
      if (cycles > 20000) begin
         fail_count++;
         stop_test();
      end
   end
   // waits for ack without a limit of its own; the cycle ceiling ends a hang
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic count_lit(input int n, input int b);
      lit = 0;
      repeat (n) begin
         @(negedge clk_i);
         if (led[b] === 1'b1) lit++;
      end
      // back onto the rising edge so the next stimulus is launched there
      @(posedge clk_i);
   endtask : count_lit
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(0, ADR_LED_EN, 0); chk("led_en", 32'h3f, q);
      wb(0, ADR_EMG_INT, 0); chk("emg_int", 32'h960, q);
      wb(0, ADR_IDLE, 0); chk("idle", 32'h12c0, q);
      wb(0, 8'h10, 0); chk("unmapped", 0, q);
      chk("led_enable_setting_off", 0, led);
      $display("reset test done");
      // sequence given while the unit is off
      op.press(0, 20); op.press(1, 20); op.press(0, 20); op.press(1, 20);
      repeat (10) @(posedge clk_i);
      wb(0, ADR_STATUS, 0); chk("status", 32'he, q & 32'he);
      chk("reports", 1, reports);
      chk("msg_flag", 1, memg);
      wb(1, ADR_EMG_INT, 32'h4);
      repeat (40) @(posedge clk_i);
      @(negedge clk_i);
      lit = reports;
      repeat (320) @(negedge clk_i);
      chk("rep_interval", lit + 10, reports);
      count_lit(64, 0); chk("emg_pwr_lit", 32, lit);
      count_lit(64, 5); chk("emg_sat_lit", 32, lit);
      slp <= 1'b1;
      repeat (4) @(posedge clk_i);
      count_lit(160, 0); chk("sleep_lit", 8, lit);
      chk("sleep_others", 0, led[5:1]);
      chk("asleep", 0, awake);
      slp <= 1'b0;
      wb(1, ADR_LED_EN, 0);
      count_lit(64, 0); chk("disabled_lit", 0, lit);
      wb(1, ADR_LED_EN, 32'h3f);
      $display("emergency test done");
      op.press(0, 200);
      repeat (10) @(posedge clk_i);
      chk("off_power", 0, pwr_on); chk("off_emg", 0, remg);
      chk("off_led_enable_setting", 0, led);
      op.press(0, 200);
      repeat (10) @(posedge clk_i);
      chk("on_power", 1, pwr_on); chk("on_emg", 0, remg);
      chk("on_led_enable_setting", 32'h37, led);
      chk("awake", 1, awake);
      at_cmd <= 1'b1;
      @(posedge clk_i);
      at_cmd <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("at_ok", 1, oks);
      wb(1, ADR_IDLE, 32'h10);
      op.press(1, 200);
      chk("radio_on", 1, radio);
      chk("link_led", 1, led[3]);
      repeat (150) @(posedge clk_i);
      chk("radio_idle", 0, radio);
      $display("power test done");
      battery_level_led <= BATTERY_LEVEL_LED_LOW;
      repeat (2) @(posedge clk_i);
      count_lit(72, 1); chk("battery_level_led_low", 8, lit);
      chg <= 1'b1;
      repeat (2) @(posedge clk_i);
      count_lit(96, 1); chk("charging", 80, lit);
      fix <= FIX_2D;
      sat <= 3'h2;
      repeat (2) @(posedge clk_i);
      count_lit(64, 2); chk("fix_2d", 32, lit);
      count_lit(64, 5); chk("sat_low", 32, lit);
      sat <= 3'h0;
      repeat (2) @(posedge clk_i);
      ext <= 1'b1;
      count_lit(256, 5); chk("sweep_sat", 48, lit);
      chk("sweep_done", 1, led[4]);
      $display("status test done");
      stop_test();
   end
endmodule : tsl_status_ctrl_test
